// ### hw/ufd_byte_fifo.sv
// Purpose: byte fifo of up to 64 entries with a run-time depth limit
// Assumes: limit is 1, 16 or 64 and changes only together with a clear
// Notes: push beyond the limit is refused; clear empties in one edge
`timescale 1ns/1ps
`default_nettype none
module ufd_byte_fifo (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic clear,
  input wire logic [6:0] limit,
  // fill side
  input wire logic pushValid,
  input wire logic [7:0] pushData,
  output logic pushReady,
  // drain side
  output logic popValid,
  input wire logic popReady,
  output logic [7:0] popData,
  // fill level
  output logic [6:0] count
);

  logic [7:0] mem [0:63];
  logic [5:0] wrPtr;
  logic [5:0] rdPtr;
  logic doPush;
  logic doPop;

  // handshakes
  assign pushReady = (count < limit);
  assign popValid = (count != 7'h00);
  assign doPush = pushValid && pushReady && !clear;
  assign doPop = popReady && popValid && !clear;
  assign popData = mem[rdPtr];

  // storage
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  // pointers and level; clear leaves outside shift logic alone
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= 6'h00;
      rdPtr <= 6'h00;
      count <= 7'h00;
    end else if (clear) begin
      wrPtr <= 6'h00;
      rdPtr <= 6'h00;
      count <= 7'h00;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 6'h01;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 6'h01;
      end
      if (doPush && !doPop) begin
        count <= count + 7'h01;
      end else if (doPop && !doPush) begin
        count <= count - 7'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/ufd_fifo_ctrl.sv
// Purpose: fifo control, dma ready strobes and prioritized interrupt status
// Assumes: host port strobes are one-cycle pulses synchronous to ref_clk
// Notes: framing, baud and line details live in the serial core outside
`timescale 1ns/1ps
`default_nettype none
`include "ufd_params.svh"
module ufd_fifo_ctrl #(
  parameter int RX_TIMEOUT_CYC = (`UFD_TIMEOUT_CHARS * `UFD_CHAR_TIME_NS) / `UFD_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host register port
  input wire logic [2:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // dma ready strobes and interrupt
  output logic tx_space_ready_n,
  output logic rx_char_ready_n,
  output logic intReq,
  // transmit shift register side
  input wire logic txLoad,
  output logic txCharAvail,
  output logic [7:0] txLoadData,
  // receive shift register side
  input wire logic rxCharValid,
  input wire logic [7:0] rxCharData,
  // status events from the serial core
  input wire logic lineErrEvent,
  input wire logic modemEvent
);

  logic fifoEn;
  logic dmaMode1;
  logic deep64;
  logic [1:0] trigSel;
  logic [3:0] interrupt_enable_reg;
  logic wrData;
  logic wrIer;
  logic wrFcr;
  logic rdData;
  logic rdIsr;
  logic modeChange;
  logic txClr;
  logic rxClr;
  logic [6:0] depthLimit;
  logic [6:0] rxTrig;
  logic mode1;
  logic txPushReady;
  logic [6:0] txCount;
  logic rxPushReady;
  logic rxPopValid;
  logic [7:0] rxPopData;
  logic [6:0] rxCount;
  logic lsPend;
  logic toPend;
  logic thrPend;
  logic msPend;
  logic txLow;
  logic txLowPrev;
  logic lineSet;
  logic rxLevel;
  logic [4:0] enSrc;
  logic [19:0] toTimer;
  logic toHit;
  logic rxHold;
  logic txFullHold;
  ufd_pkg::ufd_int_t curId;
  ufd_pkg::ufd_int_t next_curId;
  logic [7:0] isrValue;
  localparam logic [7:0] FCR_RST = `UFD_FCR_RESET;
  // trigger level for a code and depth
  function automatic logic [6:0] trigLevel(input logic [1:0] sel, input logic deep);
    logic [6:0] lvl;
    lvl = `UFD_TRIG16_0;
    unique case (sel)
      2'h0: lvl = deep ? `UFD_TRIG64_0 : `UFD_TRIG16_0;
      2'h1: lvl = deep ? `UFD_TRIG64_1 : `UFD_TRIG16_1;
      2'h2: lvl = deep ? `UFD_TRIG64_2 : `UFD_TRIG16_2;
      2'h3: lvl = deep ? `UFD_TRIG64_3 : `UFD_TRIG16_3;
    endcase
    return lvl;
  endfunction
  // status code for a reported interrupt
  function automatic logic [3:0] intCode(input ufd_pkg::ufd_int_t id);
    logic [3:0] code;
    code = `UFD_CODE_NONE;
    unique case (id)
      ufd_pkg::UFD_INT_NONE: code = `UFD_CODE_NONE;
      ufd_pkg::UFD_INT_LINE: code = `UFD_CODE_LINE;
      ufd_pkg::UFD_INT_RXDATA: code = `UFD_CODE_RXDATA;
      ufd_pkg::UFD_INT_TIMEOUT: code = `UFD_CODE_TIMEOUT;
      ufd_pkg::UFD_INT_THRE: code = `UFD_CODE_THRE;
      ufd_pkg::UFD_INT_MODEM: code = `UFD_CODE_MODEM;
    endcase
    return code;
  endfunction
  // register port decode
  assign wrData = regWrite && (regAddr == `UFD_OFF_DATA);
  assign wrIer = regWrite && (regAddr == `UFD_OFF_IER);
  assign wrFcr = regWrite && (regAddr == `UFD_OFF_FIFO);
  assign rdData = regRead && (regAddr == `UFD_OFF_DATA);
  assign rdIsr = regRead && (regAddr == `UFD_OFF_FIFO);
  // fifos are flushed whenever enable or depth changes
  assign modeChange = wrFcr && ((regWrData[`UFD_FCR_ENABLE] != fifoEn) ||
                      (regWrData[`UFD_FCR_ENABLE] && (regWrData[`UFD_FCR_DEEP] != deep64)));
  assign txClr = modeChange || (wrFcr && regWrData[`UFD_FCR_ENABLE] && regWrData[`UFD_FCR_TXCLR]);
  assign rxClr = modeChange || (wrFcr && regWrData[`UFD_FCR_ENABLE] && regWrData[`UFD_FCR_RXCLR]);
  // depth and trigger selection
  assign depthLimit = !fifoEn ? `UFD_DEPTH_SINGLE : (deep64 ? `UFD_DEPTH_DEEP : `UFD_DEPTH_SHALLOW);
  assign rxTrig = trigLevel(trigSel, deep64);
  assign mode1 = fifoEn && dmaMode1;
  // fifo control register; other fields only take with bit 0 set
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifoEn <= FCR_RST[`UFD_FCR_ENABLE];
      dmaMode1 <= FCR_RST[`UFD_FCR_DMA];
      deep64 <= FCR_RST[`UFD_FCR_DEEP];
      trigSel <= `UFD_TRIG_RESET;
    end else if (wrFcr) begin
      fifoEn <= regWrData[`UFD_FCR_ENABLE];
      if (regWrData[`UFD_FCR_ENABLE]) begin
        dmaMode1 <= regWrData[`UFD_FCR_DMA];
        deep64 <= regWrData[`UFD_FCR_DEEP];
        trigSel <= regWrData[`UFD_FCR_TRIG_HI:`UFD_FCR_TRIG_LO];
      end
    end
  end
  // interrupt enable register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_reg <= `UFD_IER_RESET;
    end else if (wrIer) begin
      interrupt_enable_reg <= regWrData[3:0];
    end
  end
  // transmit fifo, drained by the shift register
  ufd_byte_fifo txFifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(txClr),
    .limit(depthLimit),
    .pushValid(wrData),
    .pushData(regWrData),
    .pushReady(txPushReady),
    .popValid(txCharAvail),
    .popReady(txLoad),
    .popData(txLoadData),
    .count(txCount)
  );
  // receive fifo, filled by the shift register up to full
  ufd_byte_fifo rxFifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(rxClr),
    .limit(depthLimit),
    .pushValid(rxCharValid),
    .pushData(rxCharData),
    .pushReady(rxPushReady),
    .popValid(rxPopValid),
    .popReady(rdData),
    .popData(rxPopData),
    .count(rxCount)
  );
  // receive data level: trigger in fifo mode, one char otherwise
  assign rxLevel = fifoEn ? (rxCount >= rxTrig) : (rxCount != 7'h00);
  // transmit service level: below trigger in mode 1, empty otherwise
  assign txLow = mode1 ? (txCount < rxTrig) : (txCount == 7'h00);
  // overrun counts as a line status event
  assign lineSet = lineErrEvent || (rxCharValid && !rxPushReady && !rxClr);
  // line status pending; a new event beats the clearing read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lsPend <= 1'b0;
    end else if (lineSet) begin
      lsPend <= 1'b1;
    end else if (rdIsr && curId == ufd_pkg::UFD_INT_LINE) begin
      lsPend <= 1'b0;
    end
  end
  // modem status pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msPend <= 1'b0;
    end else if (modemEvent) begin
      msPend <= 1'b1;
    end else if (rdIsr && curId == ufd_pkg::UFD_INT_MODEM) begin
      msPend <= 1'b0;
    end
  end
  // holding register empty: set on entering the low level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txLowPrev <= 1'b1;
      thrPend <= 1'b1;
    end else begin
      txLowPrev <= txLow;
      if (txLow && !txLowPrev) begin
        thrPend <= 1'b1;
      end else if (wrData || (rdIsr && curId == ufd_pkg::UFD_INT_THRE)) begin
        thrPend <= 1'b0;
      end
    end
  end
  // idle timer for characters left below the trigger
  assign toHit = fifoEn && (rxCount != 7'h00) && (toTimer == 20'(RX_TIMEOUT_CYC - 1));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      toTimer <= 20'h00000;
    end else if (!fifoEn || rxCount == 7'h00 || rxCharValid || rdData || toHit) begin
      toTimer <= 20'h00000;
    end else begin
      toTimer <= toTimer + 20'h00001;
    end
  end

  // timeout pending until data is read, the fifo empties or a status read reports it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      toPend <= 1'b0;
    end else if (toHit) begin
      toPend <= 1'b1;
    end else if (rdData || rxCount == 7'h00 || (rdIsr && curId == ufd_pkg::UFD_INT_TIMEOUT)) begin
      toPend <= 1'b0;
    end
  end

  // enabled sources: line, rx data, timeout, thr empty, modem
  assign enSrc[0] = lsPend && interrupt_enable_reg[`UFD_IER_LINE];
  assign enSrc[1] = rxLevel && interrupt_enable_reg[`UFD_IER_RX];
  assign enSrc[2] = toPend && interrupt_enable_reg[`UFD_IER_RX];
  assign enSrc[3] = thrPend && interrupt_enable_reg[`UFD_IER_TX];
  assign enSrc[4] = msPend && interrupt_enable_reg[`UFD_IER_MODEM];

  // reported interrupt: kept while its source stands, else highest pending
  always_comb begin
    next_curId = curId;
    if (curId == ufd_pkg::UFD_INT_NONE ||
        (curId == ufd_pkg::UFD_INT_LINE && !enSrc[0]) ||
        (curId == ufd_pkg::UFD_INT_RXDATA && !enSrc[1]) ||
        (curId == ufd_pkg::UFD_INT_TIMEOUT && !enSrc[2]) ||
        (curId == ufd_pkg::UFD_INT_THRE && !enSrc[3]) ||
        (curId == ufd_pkg::UFD_INT_MODEM && !enSrc[4])) begin
      if (enSrc[0]) begin
        next_curId = ufd_pkg::UFD_INT_LINE;
      end else if (enSrc[1]) begin
        next_curId = ufd_pkg::UFD_INT_RXDATA;
      end else if (enSrc[2]) begin
        next_curId = ufd_pkg::UFD_INT_TIMEOUT;
      end else if (enSrc[3]) begin
        next_curId = ufd_pkg::UFD_INT_THRE;
      end else if (enSrc[4]) begin
        next_curId = ufd_pkg::UFD_INT_MODEM;
      end else begin
        next_curId = ufd_pkg::UFD_INT_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      curId <= ufd_pkg::UFD_INT_NONE;
    end else begin
      curId <= next_curId;
    end
  end

  // status register image
  assign isrValue = {fifoEn, fifoEn, deep64, 1'b0, intCode(curId)};
  assign intReq = (curId != ufd_pkg::UFD_INT_NONE);

  // read data, registered one edge after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        `UFD_OFF_DATA: regRdData <= rxPopValid ? rxPopData : 8'h00;
        `UFD_OFF_IER: regRdData <= {4'h0, interrupt_enable_reg};
        `UFD_OFF_FIFO: regRdData <= isrValue;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // mode 1 ready holds: receive low until empty, transmit high from full to trigger
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxHold <= 1'b0;
      txFullHold <= 1'b0;
    end else begin
      if (rxCount == 7'h00) begin
        rxHold <= 1'b0;
      end else if (rxCount >= rxTrig || toHit) begin
        rxHold <= 1'b1;
      end
      if (txCount == depthLimit) begin
        txFullHold <= 1'b1;
      end else if (txCount <= rxTrig) begin
        txFullHold <= 1'b0;
      end
    end
  end

  // dma ready strobes
  assign tx_space_ready_n = mode1 ? (txFullHold || txCount == depthLimit) : (txCount != 7'h00);
  assign rx_char_ready_n = mode1 ? !((rxHold || rxCount >= rxTrig) && rxCount != 7'h00)
                                 : (rxCount == 7'h00);

  // checks
  tx_load_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrData && !mode1 && txPushReady && !txLoad && !wrFcr) |=> tx_space_ready_n)
    else $error("transmit ready not high after first load");
  rx_char_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rxCharValid && rxPushReady && !mode1 && !rdData && !rxClr && !wrFcr) |=> !rx_char_ready_n)
    else $error("receive ready not low with data held");
  tx_full_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode1 && txCount == depthLimit) |-> tx_space_ready_n)
    else $error("transmit ready low while fifo full");
  rx_hold_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode1 && !rx_char_ready_n && !rdData && !rxClr && !wrFcr) |=> !rx_char_ready_n)
    else $error("receive ready released before fifo empty");
  trig_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (deep64 && trigSel == 2'h2) |-> (rxTrig == 7'h20))
    else $error("wrong deep trigger level");
  tx_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrFcr && regWrData[`UFD_FCR_ENABLE] && regWrData[`UFD_FCR_TXCLR]) |=> (txCount == 7'h00))
    else $error("transmit fifo not emptied by clear");
  fcr_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrFcr && !regWrData[`UFD_FCR_ENABLE]) |=> (!fifoEn && $stable(trigSel) && $stable(dmaMode1)))
    else $error("control fields taken without enable bit");
  line_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rdIsr && curId == ufd_pkg::UFD_INT_LINE && !lineSet) |=> !lsPend ##1 (curId != ufd_pkg::UFD_INT_LINE))
    else $error("status read did not clear line interrupt");
  hold_report_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (curId == ufd_pkg::UFD_INT_THRE && enSrc[3] && enSrc[0]) |=> (curId == ufd_pkg::UFD_INT_THRE))
    else $error("pending interrupt preempted before service");
  status_bit0_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(intReq) |-> (!isrValue[0] && $past(isrValue[0])))
    else $error("status bit 0 disagrees with pending interrupt");

endmodule
`default_nettype wire

// ### hw/ufd_params.svh
// Purpose: constants for the fifo control, dma strobe and interrupt status block
// Assumes: byte-wide register port with a 3-bit address
// Notes: offsets are register indices on the address pins
`ifndef UFD_PARAMS_SVH
`define UFD_PARAMS_SVH

// register offsets
`define UFD_OFF_DATA 3'h0
`define UFD_OFF_IER 3'h1
`define UFD_OFF_FIFO 3'h2

// fifo control field positions
`define UFD_FCR_ENABLE 0
`define UFD_FCR_RXCLR 1
`define UFD_FCR_TXCLR 2
`define UFD_FCR_DMA 3
`define UFD_FCR_DEEP 5
`define UFD_FCR_TRIG_LO 6
`define UFD_FCR_TRIG_HI 7

// interrupt enable field positions
`define UFD_IER_RX 0
`define UFD_IER_TX 1
`define UFD_IER_LINE 2
`define UFD_IER_MODEM 3

// reset values
`define UFD_FCR_RESET 8'h00
`define UFD_IER_RESET 4'h0
`define UFD_TRIG_RESET 2'h0

// interrupt source codes, status bits 3:0
`define UFD_CODE_LINE 4'h6
`define UFD_CODE_RXDATA 4'h4
`define UFD_CODE_TIMEOUT 4'hC
`define UFD_CODE_THRE 4'h2
`define UFD_CODE_MODEM 4'h0
`define UFD_CODE_NONE 4'h1

// fifo depths and trigger levels
`define UFD_DEPTH_SINGLE 7'h01
`define UFD_DEPTH_SHALLOW 7'h10
`define UFD_DEPTH_DEEP 7'h40
`define UFD_TRIG16_0 7'h01
`define UFD_TRIG16_1 7'h04
`define UFD_TRIG16_2 7'h08
`define UFD_TRIG16_3 7'h0E
`define UFD_TRIG64_0 7'h01
`define UFD_TRIG64_1 7'h10
`define UFD_TRIG64_2 7'h20
`define UFD_TRIG64_3 7'h38

// receive timeout timing
`define UFD_CLK_PERIOD_NS 20
`define UFD_CHAR_TIME_NS 86800
`define UFD_TIMEOUT_CHARS 4

`endif

// ### hw/ufd_pkg.sv
// Purpose: shared types of the fifo control and interrupt status block
// Assumes: constants come from ufd_params.svh
// Notes: enum codes are left to the tool
package ufd_pkg;

  // interrupt currently reported in the status register
  typedef enum logic [2:0] {
    UFD_INT_NONE,
    UFD_INT_LINE,
    UFD_INT_RXDATA,
    UFD_INT_TIMEOUT,
    UFD_INT_THRE,
    UFD_INT_MODEM
  } ufd_int_t;

endpackage

// ### verif/uart_fifo_dma_interrupt_status_tb.sv
// Purpose: self-checking bench of the fifo control and interrupt status block
// Assumes: inputs change on the falling edge; short receive timeout
// Notes: expectations come from the trigger tables and status codes
`timescale 1ns/1ps
`default_nettype none
`include "ufd_params.svh"
module uart_fifo_dma_interrupt_status_tb;
  localparam int TMO = 40;
  logic ref_clk, rst_b, regRead, regWrite, intReq, txLoad, txCharAvail;
  logic tx_space_ready_n, rx_char_ready_n, rxCharValid, lineErrEvent, modemEvent;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, txLoadData, rxCharData;
  int n_errors = 0;
  int checks = 0;

  // design under test, timeout shortened
  ufd_fifo_ctrl #(.RX_TIMEOUT_CYC(TMO)) ufd_fifo_ctrl_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .tx_space_ready_n(tx_space_ready_n), .rx_char_ready_n(rx_char_ready_n),
    .intReq(intReq), .txLoad(txLoad), .txCharAvail(txCharAvail), .txLoadData(txLoadData),
    .rxCharValid(rxCharValid), .rxCharData(rxCharData), .lineErrEvent(lineErrEvent),
    .modemEvent(modemEvent));

  // far side serial core
  ufd_serial_model ufd_serial_model_inst (
    .ref_clk(ref_clk), .txLoad(txLoad), .txCharAvail(txCharAvail), .txLoadData(txLoadData),
    .rxCharValid(rxCharValid), .rxCharData(rxCharData), .lineErrEvent(lineErrEvent),
    .modemEvent(modemEvent));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // compare helpers
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // register port cycles, one-cycle strobes
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    d = regRdData;
  endtask
  // status read, then time for the next source to be taken up
  task automatic status_is(input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(`UFD_OFF_FIFO, v);
    check8("status", exp, v);
    wait_cyc(2);
  endtask
  task automatic data_is(input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(`UFD_OFF_DATA, v);
    check8("rx data", exp, v);
  endtask

  // values straight after reset
  task automatic s_reset();
    logic [7:0] v;
    check1("tx ready", 1'b0, tx_space_ready_n);
    check1("rx ready", 1'b1, rx_char_ready_n);
    check1("int", 1'b0, intReq);
    status_is(8'h01);
    reg_rd(3'h5, v);
    check8("unmapped", 8'h00, v);
  endtask

  // single-character operation, fifos off
  task automatic s_single();
    logic [7:0] v;
    reg_wr(`UFD_OFF_IER, 8'h03);
    wait_cyc(3);
    status_is(8'h02);
    status_is(8'h01);
    reg_wr(`UFD_OFF_DATA, 8'h5A);
    check1("tx ready loaded", 1'b1, tx_space_ready_n);
    ufd_serial_model_inst.take_char(v);
    check8("tx byte", 8'h5A, v);
    wait_cyc(3);
    check1("tx ready empty", 1'b0, tx_space_ready_n);
    check1("thr int", 1'b1, intReq);
    status_is(8'h02);
    ufd_serial_model_inst.send_char(8'hA5);
    wait_cyc(3);
    check1("rx ready held", 1'b0, rx_char_ready_n);
    status_is(8'h04);
    data_is(8'hA5);
    wait_cyc(2);
    check1("rx ready gone", 1'b1, rx_char_ready_n);
    check1("int gone", 1'b0, intReq);
  endtask

  // control write without the enable bit changes nothing
  task automatic s_ignore();
    reg_wr(`UFD_OFF_IER, 8'h00);
    reg_wr(`UFD_OFF_FIFO, 8'hE8);
    status_is(8'h01);
  endtask

  // every trigger code at both depths
  task automatic s_trig();
    int lv[2][4] = '{'{1, 4, 8, 14}, '{1, 16, 32, 56}};
    logic [7:0] b, v;
    for (int dp = 0; dp < 2; dp++) begin
      for (int c = 0; c < 4; c++) begin
        b = {2'b11, dp[0], 5'h00};
        reg_wr(`UFD_OFF_FIFO, {c[1:0], dp[0], 5'h07});
        reg_wr(`UFD_OFF_IER, 8'h01);
        repeat (lv[dp][c] - 1) ufd_serial_model_inst.send_char(8'h55);
        wait_cyc(3);
        status_is(b | 8'h01);
        ufd_serial_model_inst.send_char(8'hAA);
        wait_cyc(3);
        check1("int at trigger", 1'b1, intReq);
        status_is(b | 8'h04);
        reg_rd(`UFD_OFF_DATA, v);
        wait_cyc(3);
        check1("int below trigger", 1'b0, intReq);
      end
    end
  endtask

  // block mode receive: ready at trigger, held until empty, fills past trigger
  task automatic s_dma1_rx();
    reg_wr(`UFD_OFF_FIFO, 8'hCF);
    for (int i = 0; i < 16; i++) begin
      if (i == 13) check1("rx ready below", 1'b1, rx_char_ready_n);
      if (i == 14) check1("rx ready trigger", 1'b0, rx_char_ready_n);
      ufd_serial_model_inst.send_char(8'h30 + i[7:0]);
    end
    for (int i = 0; i < 16; i++) begin
      data_is(8'h30 + i[7:0]);
      if (i == 14) check1("rx ready drain", 1'b0, rx_char_ready_n);
    end
    check1("rx ready empty", 1'b1, rx_char_ready_n);
  endtask

  // block mode transmit and transmit clear
  task automatic s_dma1_tx();
    logic [7:0] v;
    reg_wr(`UFD_OFF_FIFO, 8'hCF);
    reg_wr(`UFD_OFF_IER, 8'h02);
    for (int i = 0; i < 16; i++) reg_wr(`UFD_OFF_DATA, 8'h40 + i[7:0]);
    check1("tx ready full", 1'b1, tx_space_ready_n);
    ufd_serial_model_inst.take_char(v);
    check8("tx head", 8'h40, v);
    wait_cyc(1);
    check1("tx ready 15", 1'b1, tx_space_ready_n);
    ufd_serial_model_inst.take_char(v);
    check8("tx next", 8'h41, v);
    wait_cyc(1);
    check1("tx ready trigger", 1'b0, tx_space_ready_n);
    check1("tx int at trigger", 1'b0, intReq);
    ufd_serial_model_inst.take_char(v);
    check8("tx below trigger", 8'h42, v);
    wait_cyc(3);
    check1("tx int below trigger", 1'b1, intReq);
    reg_wr(`UFD_OFF_FIFO, 8'hCD);
    check1("tx cleared", 1'b0, txCharAvail);
    reg_wr(`UFD_OFF_DATA, 8'h77);
    reg_wr(`UFD_OFF_FIFO, 8'hC9);
    check1("clear ended", 1'b1, txCharAvail);
    ufd_serial_model_inst.take_char(v);
    check8("tx after clear", 8'h77, v);
  endtask

  // masking, holding of the reported source and priority order
  task automatic s_priority();
    logic [7:0] v;
    reg_wr(`UFD_OFF_FIFO, 8'h07);
    reg_wr(`UFD_OFF_IER, 8'h00);
    reg_wr(`UFD_OFF_DATA, 8'h11);
    ufd_serial_model_inst.take_char(v);
    ufd_serial_model_inst.pulse_event(1'b0);
    wait_cyc(3);
    check1("masked", 1'b0, intReq);
    reg_wr(`UFD_OFF_IER, 8'h08);
    wait_cyc(3);
    check1("modem int", 1'b1, intReq);
    reg_wr(`UFD_OFF_IER, 8'h0F);
    ufd_serial_model_inst.pulse_event(1'b1);
    ufd_serial_model_inst.send_char(8'h22);
    wait_cyc(3);
    status_is(8'hC0);
    status_is(8'hC6);
    status_is(8'hC4);
    data_is(8'h22);
    wait_cyc(2);
    status_is(8'hC2);
    status_is(8'hC1);
  endtask

  // idle receive fifo below trigger reports a timeout
  task automatic s_timeout();
    reg_wr(`UFD_OFF_FIFO, 8'hC7);
    reg_wr(`UFD_OFF_IER, 8'h01);
    ufd_serial_model_inst.send_char(8'h3C);
    wait_cyc(TMO + 5);
    status_is(8'hCC);
    data_is(8'h3C);
    wait_cyc(2);
    status_is(8'hC1);
  endtask

  // closing report
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    int cyc;
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 8000) begin
        n_errors++;
        print_verdict();
      end
    end
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    regAddr = 3'h0;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWrData = 8'h00;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    s_reset();
    s_single();
    s_ignore();
    s_trig();
    s_dma1_rx();
    s_dma1_tx();
    s_priority();
    s_timeout();
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verif/ufd_serial_model.sv
// Purpose: serial core model on the far side of the fifo block
// Assumes: the bench calls its tasks, one at a time
// Notes: outputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module ufd_serial_model (
  // clock
  input wire logic ref_clk,
  // transmit shift register side
  output logic txLoad,
  input wire logic txCharAvail,
  input wire logic [7:0] txLoadData,
  // receive shift register side
  output logic rxCharValid,
  output logic [7:0] rxCharData,
  // status events
  output logic lineErrEvent,
  output logic modemEvent
);
  // idle levels from time zero
  initial begin
    txLoad = 1'b0;
    rxCharValid = 1'b0;
    rxCharData = 8'h00;
    lineErrEvent = 1'b0;
    modemEvent = 1'b0;
  end
  // one character per pulse; the data line shows the inverse once released
  task automatic send_char(input logic [7:0] d);
    @(negedge ref_clk);
    rxCharValid = 1'b1;
    rxCharData = d;
    @(negedge ref_clk);
    rxCharValid = 1'b0;
    rxCharData = ~d;
  endtask
  // pull the head byte once one waits, bounded so a dead fifo cannot hang us
  task automatic take_char(output logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (txCharAvail !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    d = txLoadData;
    txLoad = 1'b1;
    @(negedge ref_clk);
    txLoad = 1'b0;
  endtask
  // one-cycle status event, line error or modem change
  task automatic pulse_event(input logic line);
    @(negedge ref_clk);
    lineErrEvent = line;
    modemEvent = ~line;
    @(negedge ref_clk);
    lineErrEvent = 1'b0;
    modemEvent = 1'b0;
  endtask
endmodule
`default_nettype wire
